//--- lpmc_pkg.sv
/*
 * Shared constants and types of the low-power mode controller:
 * mode and state codes, autonomous peripheral indices and masks,
 * and the packed carriers for oscillator, power and wake signals.
 * Assumes it is compiled before every other file of the block.
 */
`default_nettype none

package lpmc_pkg;

    // Autonomous peripheral slots on the request vectors
    localparam int NPER     = 10;
    localparam int NIO      = 8;
    localparam int P_ADC    = 0;
    localparam int P_LOW_POWER_TIMER_ONE = 1;
    localparam int P_LPTIM2 = 2;
    localparam int P_USART  = 3;
    localparam int P_LPUART = 4;
    localparam int P_THIRD_SERIAL_PERIPHERAL_PORT   = 5;
    localparam int P_I2C1   = 6;
    localparam int P_THIRD_TWO_WIRE_PORT   = 7;
    localparam int P_DMA    = 8;
    localparam int P_RADIO  = 9;

    // Who may stay autonomous in Stop 0, Stop 1 and Stop 2
    localparam logic [NPER-1:0] STOP0_MASK = 10'h3ff;
    localparam logic [NPER-1:0] STOP1_MASK = 10'h0ff;
    localparam logic [NPER-1:0] STOP2_MASK = 10'h0b2;
    localparam logic [NPER-1:0] RADIO_BIT  = 10'h200;
    localparam logic [NPER-1:0] NO_PER     = 10'h000;

    typedef enum logic [2:0] {
        SEL_SLEEP   = 3'h0,
        SEL_STOP0   = 3'h1,
        SEL_STOP1   = 3'h2,
        SEL_STOP2   = 3'h3,
        SEL_STOP3   = 3'h4,
        SEL_STBY    = 3'h5,
        SEL_STBYRET = 3'h6
    } lpmc_sel_t;

    // Gray codes: each step deeper flips one bit
    typedef enum logic [2:0] {
        ST_RUN     = 3'h0,
        ST_SLEEP   = 3'h1,
        ST_STOP0   = 3'h3,
        ST_STOP1   = 3'h2,
        ST_STOP2   = 3'h6,
        ST_STOP3   = 3'h7,
        ST_STBYRET = 3'h5,
        ST_STBY    = 3'h4
    } lpmc_state_t;

    typedef enum logic [1:0] {
        IO_FLOAT    = 2'h0,
        IO_PULLUP   = 2'h1,
        IO_PULLDOWN = 2'h2
    } lpmc_io_t;

    typedef struct packed {
        logic internal_fast_rc_osc;
        logic external_fast_crystal_osc;
        logic system_pll;
        logic lowSpeedEn;
    } lpmc_osc_t;

    typedef struct packed {
        logic mainReg;
        logic low_power_regulator;
        logic coreDomainOn;
        logic cpuHalt;
        logic brownout_reset;
        logic brownoutUlp;
        logic voltage_detector;
        logic sramRetain;
        logic calTamperOn;
        logic radioRetain;
    } lpmc_pwr_t;

    typedef struct packed {
        logic sramKeep;
        logic calTamperKeep;
        logic radioKeep;
    } lpmc_stbyopt_t;

    typedef struct packed {
        logic external_reset_pin;
        logic wdgEarly;
        logic wdgReset;
        logic calEvt;
        logic tamperEvt;
        logic radioTimerEvt;
    } lpmc_wake_t;

    localparam lpmc_osc_t OSC_RESET = '{1'b1, 1'b0, 1'b0, 1'b1};
    localparam lpmc_pwr_t PWR_RESET = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

endpackage : lpmc_pkg

`default_nettype wire

//--- lpmc_wake_edge.sv
/*
 * Per-pin wake-up edge detector with selectable polarity.
 * Assumes the pin levels are already synchronous to clock.
 */
`timescale 1ns/1ns
`default_nettype none

module lpmc_wake_edge #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pinLevel,
    input  wire logic [W-1:0] risingSel,
    output logic      [W-1:0] edgePulse
);

    logic [W-1:0] prev_reg;
    logic [W-1:0] edge_reg;
    logic [W-1:0] edge_next;
    logic         armed_reg;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            edge_next[i] = armed_reg
                         && (risingSel[i] ? (pinLevel[i] & ~prev_reg[i]) : (~pinLevel[i] & prev_reg[i]));
        end
    end

    // First cycle after reset ignored: prev_reg resets low whatever the pin's idle level,
    // so a pin idling high would otherwise give a false wake edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_reg  <= '0;
            edge_reg  <= '0;
            armed_reg <= 1'b0;
        end else begin
            prev_reg  <= pinLevel;
            edge_reg  <= edge_next;
            armed_reg <= 1'b1;
        end
    end

    assign edgePulse = edge_reg;

endmodule : lpmc_wake_edge

`default_nettype wire

//--- lpmc_controller.sv
/*
 * Low-power mode controller: mode sequencing, oscillator and regulator
 * control, autonomous kernel and bus clock gating, Standby I/O pulls.
 * Assumes all inputs synchronous to clock; software picks a mode and
 * raises enterLowPower for one cycle; peripherals hold their requests.
 */
// Function
// (R1) Reset lands in Run; low power only on request
// (R2) Sleep halts CPU; any interrupt wakes
// (R3) Stop 0/1 keep registers, stop PLL, crystal
// (R4) Stop 0/1 fast RC only for autonomous use
// (R5) Bus request in Stop 1 moves to Stop 0
// (R6) Stop 0 main regulator; deeper Stops low-power
// (R7) Stop exit selects fast RC as system clock
// (R8) Brownout always on; optional ultra-low-power, detector
// (R9) Stop 2: kernel requests only, no bus clock
// (R10) Stop 2: only listed peripherals stay active
// (R11) Stop 3: all core clocks and fast oscillators off
// (R12) Standby: regulator and core domain off
// (R13) Standby I/O takes software-selected pull
// (R14) Standby wakes on reset pin, watchdog, pin edge
// (R15) Retention also wakes on calendar, tamper, radio
// (R16) Wake from Standby runs on fast RC
// (R17) Retention keeps SRAM, calendar, radio options
// (R18) Kernel clock follows any peripheral request
// (R19) Bus request starts fast RC, distributes clock
// (R20) Bus requests gone, return Stop 0 to Stop 1
// (R21) Autonomous sets per Stop 0 and Stop 1
// (R22) Peripheral interrupt wakes from Stop; code ignores it in Stop 3, which wakes only on reset pin, watchdog, pin edge
// (R23) DMA keeps running in Stop 0
// (R24) Peripherals hold requests while they need clocks
// (R25) Regulator selection per mode; Standby both off; code keeps the low-power regulator on in ST_STBYRET
`timescale 1ns/1ns
`default_nettype none

module lpmc_controller
    import lpmc_pkg::*;
#(
    parameter int NWAKE = 2
) (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                enterLowPower,
    input  wire lpmc_sel_t           modeSelect,
    input  wire logic                crystalEnRun,
    input  wire logic                pllEnRun,
    input  wire logic                sysClkAltSel,
    input  wire logic                rangeOne,
    input  wire logic                brownoutUlpCfg,
    input  wire logic                detectorKeepCfg,
    input  wire logic                sramRetainCfg,
    input  wire lpmc_stbyopt_t       stbyOptions,
    input  wire logic [2*NIO-1:0]    ioStandbyCfg,
    input  wire logic [NPER-1:0]     kernelReq,
    input  wire logic [NPER-1:0]     busReq,
    input  wire logic [NPER-1:0]     periphIrq,
    input  wire logic [NWAKE-1:0]    wakeup_pin,
    input  wire logic [NWAKE-1:0]    wakeRising,
    input  wire lpmc_wake_t          wakeEvents,
    output lpmc_state_t              powerState,
    output lpmc_osc_t                oscCtrl,
    output lpmc_pwr_t                pwrCtrl,
    output logic [NPER-1:0]          kernelClkEn,
    output logic                     busClkEn,
    output logic                     sysClkFromRc,
    output logic [NIO-1:0]           ioPullUp,
    output logic [NIO-1:0]           ioPullDown
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic isStop(input lpmc_state_t s);
        return (s == ST_STOP0) || (s == ST_STOP1) || (s == ST_STOP2) || (s == ST_STOP3);
    endfunction : isStop

    function automatic logic isStandby(input lpmc_state_t s);
        return (s == ST_STBY) || (s == ST_STBYRET);
    endfunction : isStandby

    lpmc_state_t     state_reg,    state_next;
    logic            autoStop0_reg, autoStop0_next;
    lpmc_osc_t       osc_reg,      osc_next;
    lpmc_pwr_t       pwr_reg,      pwr_next;
    logic [NPER-1:0] kclk_reg,     kclk_next;
    logic            bclk_reg,     bclk_next;
    logic            rcSys_reg,    rcSys_next;
    logic [NIO-1:0]  pullUp_reg,   pullUp_next;
    logic [NIO-1:0]  pullDn_reg,   pullDn_next;

    logic [NWAKE-1:0] pinEdge;
    logic [NPER-1:0]  stop0Mask;
    logic             wakeStop;
    logic             wakeStop3;
    logic             wakeStby;
    logic             wakeStbyRet;
    logic             stop1Bus;
    logic             stop0Bus;

    lpmc_wake_edge #(
        .W (NWAKE)
    ) u_wake_edge (
        .clock     (clock),
        .rstn      (rstn),
        .pinLevel  (wakeup_pin),
        .risingSel (wakeRising),
        .edgePulse (pinEdge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wake sources and autonomous sets
    assign stop0Mask   = rangeOne ? STOP0_MASK : (STOP0_MASK & ~RADIO_BIT);             // R21
    assign stop1Bus    = |(busReq & STOP1_MASK);                                         // R21
    assign stop0Bus    = |(busReq & stop0Mask);
    assign wakeStby    = wakeEvents.external_reset_pin | wakeEvents.wdgEarly
                       | wakeEvents.wdgReset | (|pinEdge);                               // R14
    assign wakeStbyRet = wakeStby | wakeEvents.calEvt | wakeEvents.tamperEvt
                       | wakeEvents.radioTimerEvt;                                       // R15
    assign wakeStop3   = wakeStby;
    assign wakeStop    = wakeStby | (|periphIrq);                                        // R22

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next     = state_reg;
        autoStop0_next = autoStop0_reg;
        unique case (state_reg)
            ST_RUN: begin
                autoStop0_next = 1'b0;
                if (enterLowPower) begin                                                 // R1
                    unique case (modeSelect)
                        SEL_SLEEP:   state_next = ST_SLEEP;
                        SEL_STOP0:   state_next = ST_STOP0;
                        SEL_STOP1:   state_next = ST_STOP1;
                        SEL_STOP2:   state_next = ST_STOP2;
                        SEL_STOP3:   state_next = ST_STOP3;
                        SEL_STBY:    state_next = ST_STBY;
                        SEL_STBYRET: state_next = ST_STBYRET;
                        default:     state_next = ST_RUN;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (|periphIrq || wakeStby) begin                                        // R2
                    state_next = ST_RUN;
                end
            end
            ST_STOP1: begin
                if (wakeStop) begin
                    state_next = ST_RUN;
                end else if (stop1Bus) begin                                             // R5
                    state_next     = ST_STOP0;
                    autoStop0_next = 1'b1;
                end
            end
            ST_STOP0: begin
                if (wakeStop) begin
                    state_next     = ST_RUN;
                    autoStop0_next = 1'b0;
                end else if (autoStop0_reg && !stop0Bus && modeSelect == SEL_STOP1) begin   // R20
                    state_next     = ST_STOP1;
                    autoStop0_next = 1'b0;
                end
            end
            ST_STOP2: begin
                if (wakeStop) begin
                    state_next = ST_RUN;
                end
            end
            ST_STOP3: begin
                if (wakeStop3) begin
                    state_next = ST_RUN;
                end
            end
            ST_STBY: begin
                if (wakeStby) begin                                                      // R14
                    state_next = ST_RUN;
                end
            end
            ST_STBYRET: begin
                if (wakeStbyRet) begin                                                   // R15
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs follow the next state so they change on the same edge as the mode
    always_comb begin
        kclk_next = NO_PER;
        bclk_next = 1'b0;
        unique case (state_next)
            ST_STOP0: begin
                kclk_next = kernelReq & stop0Mask;                                       // R18
                bclk_next = stop0Bus;                                                    // R19 R23
            end
            ST_STOP1: kclk_next = kernelReq & STOP1_MASK;                                // R18
            ST_STOP2: kclk_next = kernelReq & STOP2_MASK;                                // R9 R10
            default: begin
                kclk_next = NO_PER;
                bclk_next = !isStop(state_next) && !isStandby(state_next);
            end
        endcase

        osc_next            = OSC_RESET;
        osc_next.lowSpeedEn = 1'b1;
        if (isStop(state_next) || isStandby(state_next)) begin
            // Fast RC only while some autonomous user asks for it
            osc_next.internal_fast_rc_osc      = (|kclk_next) | bclk_next;               // R4 R9 R11 R19
            osc_next.external_fast_crystal_osc = 1'b0;                                   // R3 R11
            osc_next.system_pll                = 1'b0;                                   // R3 R11
        end else begin
            osc_next.internal_fast_rc_osc      = 1'b1;
            osc_next.external_fast_crystal_osc = crystalEnRun;
            osc_next.system_pll                = pllEnRun;
        end

        pwr_next                     = PWR_RESET;
        pwr_next.brownout_reset      = 1'b1;                                             // R8
        pwr_next.cpuHalt             = (state_next != ST_RUN);                           // R2
        pwr_next.coreDomainOn        = !isStandby(state_next);                           // R12
        pwr_next.mainReg             = !isStop(state_next) && !isStandby(state_next)
                                     || (state_next == ST_STOP0);                        // R6 R25
        pwr_next.low_power_regulator = (state_next == ST_STOP1) || (state_next == ST_STOP2)
                                     || (state_next == ST_STOP3) || (state_next == ST_STBYRET); // R25
        pwr_next.brownoutUlp         = brownoutUlpCfg && isStop(state_next)
                                     && (state_next != ST_STOP0);                        // R8
        pwr_next.voltage_detector    = detectorKeepCfg || !isStop(state_next);           // R8
        pwr_next.sramRetain          = isStop(state_next) ? sramRetainCfg                // R3
                                     : (state_next == ST_STBYRET) ? stbyOptions.sramKeep // R17
                                     : !isStandby(state_next);
        pwr_next.calTamperOn         = (state_next == ST_STBYRET) ? stbyOptions.calTamperKeep
                                     : (state_next != ST_STBY);                          // R17
        pwr_next.radioRetain         = (state_next == ST_STBYRET) && stbyOptions.radioKeep; // R17

        // Fast RC becomes system clock on any return from Stop or Standby
        if ((isStop(state_reg) || isStandby(state_reg)) && state_next == ST_RUN) begin
            rcSys_next = 1'b1;                                                           // R7 R16
        end else if (state_reg == ST_RUN && sysClkAltSel) begin
            rcSys_next = 1'b0;
        end else begin
            rcSys_next = rcSys_reg;
        end

        for (int i = 0; i < NIO; i++) begin
            pullUp_next[i] = isStandby(state_next)
                           && (lpmc_io_t'(ioStandbyCfg[2*i +: 2]) == IO_PULLUP);         // R13
            pullDn_next[i] = isStandby(state_next)
                           && (lpmc_io_t'(ioStandbyCfg[2*i +: 2]) == IO_PULLDOWN);       // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= ST_RUN;                                                     // R1
            autoStop0_reg <= 1'b0;
            osc_reg       <= OSC_RESET;
            pwr_reg       <= PWR_RESET;
            kclk_reg      <= NO_PER;
            bclk_reg      <= 1'b1;
            rcSys_reg     <= 1'b1;
            pullUp_reg    <= '0;
            pullDn_reg    <= '0;
        end else begin
            state_reg     <= state_next;
            autoStop0_reg <= autoStop0_next;
            osc_reg       <= osc_next;
            pwr_reg       <= pwr_next;
            kclk_reg      <= kclk_next;
            bclk_reg      <= bclk_next;
            rcSys_reg     <= rcSys_next;
            pullUp_reg    <= pullUp_next;
            pullDn_reg    <= pullDn_next;
        end
    end

    assign powerState  = state_reg;
    assign oscCtrl     = osc_reg;
    assign pwrCtrl     = pwr_reg;
    assign kernelClkEn = kclk_reg;
    assign busClkEn    = bclk_reg;
    assign sysClkFromRc = rcSys_reg;
    assign ioPullUp    = pullUp_reg;
    assign ioPullDown  = pullDn_reg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_reset_to_run: assert property (!$past(rstn) |-> state_reg == ST_RUN)   // R1
        else $error("not in Run after reset");

    a_sleep_wakes: assert property (state_reg == ST_SLEEP && (|periphIrq) |=> state_reg == ST_RUN)   // R2
        else $error("sleep did not wake on interrupt");

    a_stop1_to_stop0: assert property (state_reg == ST_STOP1 && stop1Bus && !wakeStop
        |=> state_reg == ST_STOP0 && busClkEn && oscCtrl.internal_fast_rc_osc)   // R5
        else $error("bus request in Stop 1 not served");

    a_stop0_back: assert property (state_reg == ST_STOP0 && autoStop0_reg && !stop0Bus
        && modeSelect == SEL_STOP1 && !wakeStop |=> state_reg == ST_STOP1 && !busClkEn)   // R20
        else $error("no return to Stop 1");

    a_regulator_mode: assert property (isStop(state_reg)
        |-> pwrCtrl.mainReg == (state_reg == ST_STOP0) && pwrCtrl.low_power_regulator != pwrCtrl.mainReg)   // R6
        else $error("wrong regulator in Stop");

    a_stop3_clocks: assert property (state_reg == ST_STOP3
        |-> !oscCtrl.internal_fast_rc_osc && !oscCtrl.system_pll && kernelClkEn == NO_PER)   // R11
        else $error("clock running in Stop 3");

    a_stop2_nobus: assert property (state_reg == ST_STOP2 |-> !busClkEn && (kernelClkEn & ~STOP2_MASK) == NO_PER)   // R9
        else $error("bus clock or foreign kernel clock in Stop 2");

    a_kernel_follow: assert property (state_reg == ST_STOP1 && kernelReq[P_LPUART] && !wakeStop && !stop1Bus
        |=> kernelClkEn[P_LPUART] && oscCtrl.internal_fast_rc_osc)   // R18
        else $error("kernel clock not granted");

    a_stop_exit_rc: assert property (isStop(state_reg) ##1 state_reg == ST_RUN |-> sysClkFromRc)   // R7
        else $error("fast RC not system clock after Stop");

    a_standby_off: assert property (isStandby(state_reg)
        |-> !pwrCtrl.coreDomainOn && !pwrCtrl.mainReg && pwrCtrl.brownout_reset
        && (state_reg == ST_STBY) != pwrCtrl.low_power_regulator)   // R12
        else $error("power wrong in Standby");

    a_stby_wake: assert property (state_reg == ST_STBY && wakeEvents.wdgReset |=> state_reg == ST_RUN && sysClkFromRc)   // R14
        else $error("Standby missed a wake source");

endmodule : lpmc_controller

`default_nettype wire

//--- lpmc_periph_model.sv
/*
 * Behavioural autonomous peripheral group: holds kernel and bus clock
 * requests for a commanded span, then optionally raises an interrupt.
 * Assumes go is a one-cycle pulse driven off the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none

module lpmc_periph_model
    import lpmc_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rstn,
    input  wire logic            go,
    input  wire logic [NPER-1:0] kMask,
    input  wire logic [NPER-1:0] bMask,
    input  wire logic [7:0]      len,
    input  wire logic            irqAtEnd,
    output logic      [NPER-1:0] kernelReq,
    output logic      [NPER-1:0] busReq,
    output logic      [NPER-1:0] periphIrq
);
    logic [7:0]      cntReg;
    logic [NPER-1:0] kReg;
    logic [NPER-1:0] bReg;
    logic            irqReg;

    // Requests stand while the activity lasts, dropped at its end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cntReg <= 8'h00;
            kReg   <= NO_PER;
            bReg   <= NO_PER;
            irqReg <= 1'b0;
        end else if (go) begin
            cntReg <= len;
            kReg   <= kMask;
            bReg   <= bMask;
        end else if (cntReg != 8'h00) begin
            cntReg <= cntReg - 8'h01;
            irqReg <= (cntReg == 8'h01) && irqAtEnd;
        end else begin
            irqReg <= 1'b0;
        end
    end

    assign kernelReq = (cntReg != 8'h00) ? kReg : NO_PER;
    assign busReq    = (cntReg != 8'h00) ? bReg : NO_PER;
    assign periphIrq = irqReg ? 10'h001 : NO_PER;

endmodule : lpmc_periph_model

`default_nettype wire

//--- low_power_mode_controller_tb_top.sv
/*
 * Self-checking bench of the low-power mode controller.
 * Assumes one 125 MHz clock; inputs driven on the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none

module low_power_mode_controller_tb_top;
    import lpmc_pkg::*;

    logic clock = 1'b0, rstn = 1'b0, enterLowPower = 1'b0, sysClkAltSel = 1'b0;
    logic crystalEnRun = 1'b1, pllEnRun = 1'b1, rangeOne = 1'b1;
    logic brownoutUlpCfg = 1'b1, detectorKeepCfg = 1'b1, sramRetainCfg = 1'b1;
    lpmc_sel_t modeSelect = SEL_SLEEP;
    lpmc_stbyopt_t stbyOptions = '{1'b1, 1'b0, 1'b1};
    lpmc_wake_t wakeEvents = '0;
    logic [2*NIO-1:0] ioStandbyCfg = 16'h0049;
    logic [1:0] wakeup_pin = 2'h0, wakeRising = 2'h3;
    logic go = 1'b0, irqAtEnd = 1'b0;
    logic [NPER-1:0] kMask = NO_PER, bMask = NO_PER, kernelReq, busReq, periphIrq, kernelClkEn;
    logic [7:0] len = 8'h00, ioPullUp, ioPullDown;
    lpmc_state_t powerState;
    lpmc_osc_t oscCtrl;
    lpmc_pwr_t pwrCtrl;
    logic busClkEn, sysClkFromRc;
    int n_errors = 0, n_checks = 0;

    always #4 clock = ~clock;

    lpmc_periph_model u_per (.clock(clock), .rstn(rstn), .go(go), .kMask(kMask), .bMask(bMask), .len(len),
        .irqAtEnd(irqAtEnd), .kernelReq(kernelReq), .busReq(busReq), .periphIrq(periphIrq));

    lpmc_controller #(.NWAKE(2)) u_dut (.clock(clock), .rstn(rstn), .enterLowPower(enterLowPower),
        .modeSelect(modeSelect), .crystalEnRun(crystalEnRun), .pllEnRun(pllEnRun),
        .sysClkAltSel(sysClkAltSel), .rangeOne(rangeOne), .brownoutUlpCfg(brownoutUlpCfg),
        .detectorKeepCfg(detectorKeepCfg), .sramRetainCfg(sramRetainCfg), .stbyOptions(stbyOptions),
        .ioStandbyCfg(ioStandbyCfg), .kernelReq(kernelReq), .busReq(busReq), .periphIrq(periphIrq),
        .wakeup_pin(wakeup_pin), .wakeRising(wakeRising), .wakeEvents(wakeEvents),
        .powerState(powerState), .oscCtrl(oscCtrl), .pwrCtrl(pwrCtrl), .kernelClkEn(kernelClkEn),
        .busClkEn(busClkEn), .sysClkFromRc(sysClkFromRc), .ioPullUp(ioPullUp), .ioPullDown(ioPullDown));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    // Outputs settle half a cycle after the edge that takes the request
    task automatic enter(input lpmc_sel_t s);
        modeSelect    = s;
        enterLowPower = 1'b1;
        @(negedge clock);
        enterLowPower = 1'b0;
    endtask : enter

    task automatic kick(input logic [NPER-1:0] k, input logic [NPER-1:0] b, input logic [7:0] n, input logic irq);
        kMask = k; bMask = b; len = n; irqAtEnd = irq; go = 1'b1;
        @(negedge clock);
        go = 1'b0;
    endtask : kick

    task automatic wait_state(input lpmc_state_t s);
        for (int i = 0; i < 20 && powerState !== s; i++) @(negedge clock);
        chk("powerState", powerState, s);
    endtask : wait_state

    task automatic alt_clock;
        sysClkAltSel = 1'b1;
        @(negedge clock);
        sysClkAltSel = 1'b0;
        chk("sysClkFromRc", sysClkFromRc, 1'b0);
    endtask : alt_clock

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(8 * 3000);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        chk("runAfterReset", powerState, ST_RUN);
        chk("rcAfterReset", sysClkFromRc, 1'b1);
        chk("runOsc", oscCtrl, 4'hf);
        repeat (3) @(negedge clock);
        chk("stillRun", powerState, ST_RUN);
        enter(SEL_SLEEP);
        chk("sleepHalt", {powerState, pwrCtrl.cpuHalt, pwrCtrl.coreDomainOn}, {ST_SLEEP, 2'b11});
        kick(NO_PER, NO_PER, 8'h01, 1'b1);
        wait_state(ST_RUN);
        alt_clock();
        enter(SEL_STOP1);
        chk("stop1Osc", {oscCtrl.system_pll, oscCtrl.external_fast_crystal_osc, oscCtrl.internal_fast_rc_osc}, 3'h0);
        chk("stop1Reg", {pwrCtrl.mainReg, pwrCtrl.low_power_regulator, busClkEn}, 3'b010);
        chk("stop1Bor", {pwrCtrl.brownout_reset, pwrCtrl.brownoutUlp, pwrCtrl.sramRetain}, 3'b111);
        chk("stop1OscAll", oscCtrl, 4'h1);
        chk("stop1Pvd", pwrCtrl.voltage_detector, 1'b1);
        kick(NO_PER, 10'h010, 8'h04, 1'b0);
        wait_state(ST_STOP0);
        chk("stop0Bus", {busClkEn, oscCtrl.internal_fast_rc_osc, pwrCtrl.mainReg}, 3'b111);
        wait_state(ST_STOP1);
        chk("stop1Back", {busClkEn, oscCtrl.internal_fast_rc_osc}, 2'b00);
        kick(10'h113, NO_PER, 8'h04, 1'b1);
        @(negedge clock);
        chk("stop1Kernel", kernelClkEn, 10'h013);
        chk("stop1RcOn", oscCtrl.internal_fast_rc_osc, 1'b1);
        wait_state(ST_RUN);
        chk("stopExitRc", sysClkFromRc, 1'b1);
        detectorKeepCfg = 1'b0;
        enter(SEL_STOP2);
        kick(10'h013, 10'h010, 8'h04, 1'b1);
        @(negedge clock);
        chk("stop2Kernel", kernelClkEn, 10'h012);
        chk("stop2NoBus", {powerState, busClkEn, oscCtrl.internal_fast_rc_osc}, {ST_STOP2, 2'b01});
        chk("stop2Pvd", pwrCtrl.voltage_detector, 1'b0);
        wait_state(ST_RUN);
        enter(SEL_STOP3);
        kick(10'h012, NO_PER, 8'h01, 1'b1);
        repeat (3) @(negedge clock);
        chk("stop3Hold", {powerState, oscCtrl.internal_fast_rc_osc, kernelClkEn}, {ST_STOP3, 11'h000});
        wakeup_pin = 2'h1;
        wait_state(ST_RUN);
        wakeup_pin = 2'h0;
        alt_clock();
        enter(SEL_STBY);
        chk("stbyPwr", {pwrCtrl.mainReg, pwrCtrl.low_power_regulator, pwrCtrl.coreDomainOn}, 3'h0);
        chk("stbyPull", {ioPullUp, ioPullDown}, 16'h0902);
        wakeEvents.calEvt = 1'b1;
        repeat (2) @(negedge clock);
        chk("stbyCalIgnored", powerState, ST_STBY);
        wakeEvents = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        wait_state(ST_RUN);
        wakeEvents = '0;
        chk("stbyExit", {sysClkFromRc, ioPullUp}, 9'h100);
        enter(SEL_STBYRET);
        chk("retPwr", {pwrCtrl.mainReg, pwrCtrl.low_power_regulator}, 2'b01);
        chk("retOpt", {pwrCtrl.sramRetain, pwrCtrl.calTamperOn, pwrCtrl.radioRetain}, 3'b101);
        wakeEvents.radioTimerEvt = 1'b1;
        wait_state(ST_RUN);
        wakeEvents = '0;
        rangeOne = 1'b0;
        alt_clock();
        enter(SEL_STOP0);
        kick(10'h300, 10'h300, 8'h04, 1'b1);
        @(negedge clock);
        chk("stop0Auto", {kernelClkEn, busClkEn, pwrCtrl.mainReg}, {10'h100, 2'b11});
        rstn = 1'b0;
        @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        chk("midReset", {powerState, sysClkFromRc, busClkEn, kernelClkEn}, {ST_RUN, 2'b11, 10'h000});
        finish_test();
    end

endmodule : low_power_mode_controller_tb_top

`default_nettype wire
